// >>> hdl/tso_exec.sv
// execution slice for test-and-skip and the two xor opcodes
// assumes one instruction word per clock, file data returned combinationally
`timescale 1ns/1ps
module tso_exec
   import tso_pkg::*;
(
   input  wire logic        ref_clk,
   input  wire logic        sys_rst,
   input  wire logic [15:0] instr_word,
   input  wire logic        instr_valid,
   input  wire logic        next_is_two_word,
   input  wire logic [3:0]  bank_pointer,
   input  wire logic        extended_set_enable_bit,
   input  wire logic [11:0] index_base,
   input  wire logic [7:0]  file_rdata,
   output logic      [11:0] file_addr,
   output logic             file_we_q,
   output logic      [11:0] file_waddr_q,
   output logic      [7:0]  file_wdata_q,
   output logic      [7:0]  acc_q,
   output logic      [1:0]  status_q,
   output logic             discard_q,
   output logic             busy_q,
   output tso_pkg::tso_amode_t amode_q
);
   import tso_pkg::*;

   typedef struct packed {
      logic        we;
      logic [11:0] waddr;
      logic [7:0]  wdata;
      logic [7:0]  acc;
      logic [1:0]  stat;
      logic        discard;
      logic [1:0]  nops;
      logic        ext_en;
      tso_amode_t  amode;
   } tso_state_t;

   tso_state_t  s_q;
   tso_state_t  s_d;
   tso_amode_t  mode;
   logic [7:0]  result;
   logic        is_skip;
   logic        is_xlit;
   logic        is_xreg;

   ////////////////////////////////////////////////////////////////////////////
   tso_addr_gen u_addr (
      .addr_field   (instr_word[7:0]),
      .low_pick     (instr_word[BIT_A]),
      .bank_pointer (bank_pointer),
      .ext_enable   (s_q.ext_en),
      .index_base   (index_base),
      .mode         (mode),
      .file_addr    (file_addr)
   );

   ////////////////////////////////////////////////////////////////////////////
   always_comb
   begin
      is_skip = instr_word[15:9] == OPC_TEST_SKIP;
      is_xlit = instr_word[15:8] == OPC_XOR_LIT;
      is_xreg = instr_word[15:10] == OPC_XOR_REG;
      result  = is_xlit ? (s_q.acc ^ instr_word[7:0])
                        : (s_q.acc ^ file_rdata);
      s_d          = s_q;
      s_d.we       = 1'b0;
      s_d.discard  = 1'b0;
      s_d.ext_en   = extended_set_enable_bit;
      if (s_q.nops != NOP_NONE)
      begin
         // word shown in a nop cycle is dropped; discard_q follows the remaining count
         s_d.nops    = s_q.nops - NOP_ONE;
         s_d.discard = s_q.nops != NOP_ONE;
      end
      else if (instr_valid)
      begin
         s_d.amode = mode;
         if (is_skip && file_rdata == 8'h00)
         begin
            // a two-word target needs a second nop cycle
            s_d.discard = 1'b1;
            s_d.nops    = next_is_two_word ? NOP_TWO : NOP_ONE;
         end
         else if (is_xlit)
         begin
            s_d.acc = result;
            s_d.stat[STAT_ZERO] = result == 8'h00;
            s_d.stat[STAT_NEG]  = result[SIGN_BIT];
         end
         else if (is_xreg)
         begin
            if (instr_word[BIT_D])
            begin
               s_d.we    = 1'b1;
               s_d.waddr = file_addr;
               s_d.wdata = result;
            end
            else
            begin
               s_d.acc = result;
            end
            s_d.stat[STAT_ZERO] = result == 8'h00;
            s_d.stat[STAT_NEG]  = result[SIGN_BIT];
         end
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         s_q <= '{we: 1'b0, waddr: 12'h000, wdata: 8'h00, acc: ACC_RESET,
                  stat: STAT_RESET, discard: 1'b0, nops: NOP_NONE, ext_en: 1'b0,
                  amode: ADDR_BANKED};
      end
      else
      begin
         s_q <= s_d;
      end
   end

   assign file_we_q    = s_q.we;
   assign file_waddr_q = s_q.waddr;
   assign file_wdata_q = s_q.wdata;
   assign acc_q        = s_q.acc;
   assign status_q     = s_q.stat;
   assign discard_q    = s_q.discard;
   assign busy_q       = s_q.nops != NOP_NONE;
   assign amode_q      = s_q.amode;

   ////////////////////////////////////////////////////////////////////////////
   // execution results, looked at one cycle after the word is taken; banked address and indexed mode checked in the same cycle
   a_skip_discard: assert property (@(posedge ref_clk) disable iff (sys_rst)
      instr_valid && !busy_q && is_skip && file_rdata == 8'h00 |=> discard_q)
      else $error("skip did not discard next word");
   a_skip_two_word: assert property (@(posedge ref_clk) disable iff (sys_rst)
      instr_valid && !busy_q && is_skip && file_rdata == 8'h00 && next_is_two_word
      |=> discard_q ##1 discard_q ##1 !busy_q)
      else $error("two-word skip length wrong");
   a_xlit_acc: assert property (@(posedge ref_clk) disable iff (sys_rst)
      instr_valid && !busy_q && is_xlit |=> acc_q == ($past(acc_q) ^ $past(instr_word[7:0])))
      else $error("xor literal result wrong");
   a_skip_flags: assert property (@(posedge ref_clk) disable iff (sys_rst)
      instr_valid && !busy_q && is_skip |=> $stable(status_q))
      else $error("test-skip changed flags");
   a_xreg_write: assert property (@(posedge ref_clk) disable iff (sys_rst)
      instr_valid && !busy_q && is_xreg && instr_word[BIT_D]
      |=> file_we_q && file_wdata_q == ($past(acc_q) ^ $past(file_rdata)))
      else $error("xor register write wrong");
   a_xreg_to_acc: assert property (@(posedge ref_clk) disable iff (sys_rst)
      instr_valid && !busy_q && is_xreg && !instr_word[BIT_D]
      |=> !file_we_q && acc_q == ($past(acc_q) ^ $past(file_rdata)))
      else $error("xor register to acc wrong");
   a_zero_flag: assert property (@(posedge ref_clk) disable iff (sys_rst)
      instr_valid && !busy_q && (is_xlit || is_xreg)
      |=> status_q[STAT_ZERO] == (($past(result)) == 8'h00)
          && status_q[STAT_NEG] == $past(result[SIGN_BIT]))
      else $error("xor flags wrong");
   a_banked_addr: assert property (@(posedge ref_clk) disable iff (sys_rst)
      instr_word[BIT_A] |-> file_addr == {bank_pointer, instr_word[7:0]})
      else $error("banked address wrong");
   a_ilo_off: assert property (@(posedge ref_clk) disable iff (sys_rst)
      !s_q.ext_en |-> mode != ADDR_INDEXED)
      else $error("indexed mode while extension off");
   a_ilo_mode: assert property (@(posedge ref_clk) disable iff (sys_rst)
      s_q.ext_en && !instr_word[BIT_A] && instr_word[7:0] <= ILO_LIMIT
      |-> mode == ADDR_INDEXED)
      else $error("indexed mode not selected");

   // skip sequencing: every word presented while busy_q is high is a nop
   a_single_skip_len: assert property (@(posedge ref_clk) disable iff (sys_rst)
      instr_valid && !busy_q && is_skip && file_rdata == 8'h00 && !next_is_two_word
      |=> busy_q ##1 !busy_q)
      else $error("single skip length wrong");
   a_busy_ignored: assert property (@(posedge ref_clk) disable iff (sys_rst)
      busy_q
      |=> $stable(acc_q) && $stable(status_q) && !file_we_q)
      else $error("word executed in a skip cycle");
   a_skip_no_write: assert property (@(posedge ref_clk) disable iff (sys_rst)
      instr_valid && !busy_q && is_skip
      |=> !file_we_q && $stable(acc_q))
      else $error("test-skip changed data");
   a_no_skip_run: assert property (@(posedge ref_clk) disable iff (sys_rst)
      instr_valid && !busy_q && is_skip && file_rdata != 8'h00
      |=> !discard_q && !busy_q)
      else $error("skip taken on nonzero register");
   a_xreg_acc_kept: assert property (@(posedge ref_clk) disable iff (sys_rst)
      instr_valid && !busy_q && is_xreg && instr_word[BIT_D]
      |=> $stable(acc_q))
      else $error("xor register to file touched acc");

   // address forming
   a_access_addr: assert property (@(posedge ref_clk) disable iff (sys_rst)
      !instr_word[BIT_A] && (!s_q.ext_en || instr_word[7:0] > ILO_LIMIT)
      |-> mode == ADDR_ACCESS)
      else $error("access bank not selected");
   a_access_high: assert property (@(posedge ref_clk) disable iff (sys_rst)
      mode == ADDR_ACCESS && instr_word[7:0] >= ACC_HIGH_BASE
      |-> file_addr == {ACC_HIGH_BANK, instr_word[7:0]})
      else $error("access bank upper half wrong");
   a_indexed_addr: assert property (@(posedge ref_clk) disable iff (sys_rst)
      mode == ADDR_INDEXED
      |-> file_addr == index_base + {4'h0, instr_word[7:0]})
      else $error("indexed address wrong");

   // extension bit is taken one cycle late and never forced on
   a_ext_follows: assert property (@(posedge ref_clk) disable iff (sys_rst)
      1'b1
      |=> s_q.ext_en == $past(extended_set_enable_bit))
      else $error("extension enable not tracked");
endmodule : tso_exec

// >>> hdl/tso_pkg.sv
// package of opcode fields, addressing constants and status layout for the
// test-skip / xor execution block; no assumptions beyond a single clock
package tso_pkg;
   localparam logic [6:0]  OPC_TEST_SKIP  = 7'h33;     // 0110 011
   localparam logic [7:0]  OPC_XOR_LIT    = 8'h0A;     // 0000 1010
   localparam logic [5:0]  OPC_XOR_REG    = 6'h06;     // 0001 10
   localparam logic [7:0]  ILO_LIMIT      = 8'h5F;     // indexed offset window top
   localparam logic [7:0]  ACC_HIGH_BASE  = 8'h60;     // upper half of access bank
   localparam logic [3:0]  ACC_HIGH_BANK  = 4'hF;      // bank of sfr half
   localparam logic [3:0]  ACC_LOW_BANK   = 4'h0;
   localparam logic [7:0]  ACC_RESET      = 8'h00;
   localparam logic [1:0]  STAT_RESET     = 2'h0;
   localparam int          STAT_NEG       = 1;
   localparam int          STAT_ZERO      = 0;
   localparam int          SIGN_BIT       = 7;
   localparam int          BIT_A          = 8;
   localparam int          BIT_D          = 9;
   localparam logic [1:0]  NOP_ONE        = 2'h1;
   localparam logic [1:0]  NOP_TWO        = 2'h2;
   localparam logic [1:0]  NOP_NONE       = 2'h0;
   typedef enum logic [1:0] {ADDR_BANKED, ADDR_ACCESS, ADDR_INDEXED} tso_amode_t;
endpackage : tso_pkg

// >>> hdl/tso_addr_gen.sv
// file-register address former: banked, access bank or indexed literal offset
// assumes the caller supplies the bank pointer and the indexed base pointer
`timescale 1ns/1ps
module tso_addr_gen
   import tso_pkg::*;
(
   input  wire logic [7:0]  addr_field,
   input  wire logic        low_pick,
   input  wire logic [3:0]  bank_pointer,
   input  wire logic        ext_enable,
   input  wire logic [11:0] index_base,
   output tso_pkg::tso_amode_t mode,
   output logic      [11:0] file_addr
);
   always_comb
   begin
      if (low_pick)
      begin
         mode      = ADDR_BANKED;
         file_addr = {bank_pointer, addr_field};
      end
      else if (ext_enable && addr_field <= ILO_LIMIT)
      begin
         mode      = ADDR_INDEXED;
         file_addr = index_base + {4'h0, addr_field};
      end
      else
      begin
         mode      = ADDR_ACCESS;
         file_addr = (addr_field >= ACC_HIGH_BASE) ? {ACC_HIGH_BANK, addr_field}
                                                   : {ACC_LOW_BANK, addr_field};
      end
   end
endmodule : tso_addr_gen

// >>> dv/tb_tso_exec.sv
// self-checking bench for the test-skip / xor execution slice
// assumes the bench supplies file data in the cycle an address is shown
`timescale 1ns/1ps
module tb_tso_exec;
   import tso_pkg::*;
   logic        ref_clk = 1'b0;
   logic        sys_rst = 1'b1;
   logic [15:0] instr_word = 16'h0000;
   logic        instr_valid = 1'b0;
   logic        next_is_two_word = 1'b0;
   logic [3:0]  bank_pointer = 4'h0;
   logic        extended_set_enable_bit = 1'b0;
   logic [11:0] index_base = 12'h000;
   logic [7:0]  file_rdata = 8'h00;
   logic [11:0] file_addr, file_waddr_q;
   logic [7:0]  file_wdata_q, acc_q;
   logic [1:0]  status_q;
   logic        file_we_q, discard_q, busy_q;
   tso_amode_t  amode_q;
   int          fail_count = 0;
   int          check_count = 0;

   always #2.5 ref_clk = ~ref_clk;

   tso_exec i_dut (.ref_clk, .sys_rst, .instr_word, .instr_valid, .next_is_two_word,
      .bank_pointer, .extended_set_enable_bit, .index_base, .file_rdata, .file_addr,
      .file_we_q, .file_waddr_q, .file_wdata_q, .acc_q, .status_q, .discard_q, .busy_q,
      .amode_q);

   ////////////////////////////////////////////////////////////////////////////////
   task automatic stop_test;
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : stop_test

   task automatic check(input logic [23:0] seen, input logic [23:0] exp, input string what);
      check_count++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask : check

   // present one instruction; it is taken at the following rising edge
   task automatic drive(input logic [15:0] word, input logic [7:0] rdata);
      @(negedge ref_clk);
      instr_word  = word;
      file_rdata  = rdata;
      instr_valid = 1'b1;
      #1;
   endtask : drive

   task automatic step;
      @(negedge ref_clk);
      instr_valid = 1'b0;
   endtask : step

   function automatic logic [15:0] xl(input logic [7:0] k);
      return {OPC_XOR_LIT, k};
   endfunction : xl

   function automatic logic [15:0] xw(input logic d, input logic a, input logic [7:0] f);
      return {OPC_XOR_REG, d, a, f};
   endfunction : xw

   function automatic logic [15:0] ts(input logic a, input logic [7:0] f);
      return {OPC_TEST_SKIP, a, f};
   endfunction : ts

   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (8) @(negedge ref_clk);
      sys_rst = 1'b0;
      check({acc_q, status_q}, {ACC_RESET, STAT_RESET}, "reset state");
      drive(xl(8'hAF), 8'h00);
      step();
      check(acc_q, 8'hAF, "xor literal");
      check(status_q, 2'h2, "negative flag");
      drive(xl(8'hAF), 8'h00);
      step();
      check(status_q, 2'h1, "zero flag");
      drive(xl(8'hB5), 8'h00);
      step();
      check({acc_q, status_q}, {8'hB5, 2'h2}, "xor literal from zero");
      $display("test xor literal done");
      bank_pointer = 4'h3;
      drive(xw(1'b0, 1'b1, 8'h22), 8'hAF);
      check(file_addr, 12'h322, "banked address");
      step();
      check(acc_q, 8'h1A, "xor register to acc");
      check(file_we_q, 1'b0, "no file write");
      check({amode_q, status_q}, {ADDR_BANKED, 2'h0}, "banked mode, flags clear");
      drive(xw(1'b1, 1'b0, 8'h80), 8'h1A);
      check(file_addr, 12'hF80, "access high address");
      step();
      check({file_we_q, file_waddr_q, file_wdata_q}, {1'b1, 12'hF80, 8'h00}, "write back");
      check({acc_q, status_q}, {8'h1A, 2'h1}, "acc kept, zero set");
      $display("test xor register done");
      drive(ts(1'b0, 8'h5F), 8'h01);
      check(file_addr, 12'h05F, "extension off");
      step();
      check(amode_q, ADDR_ACCESS, "access mode");
      check({discard_q, status_q}, 3'h1, "no skip, flags kept");
      extended_set_enable_bit = 1'b1;
      index_base = 12'h200;
      repeat (2) @(negedge ref_clk);
      drive(ts(1'b0, 8'h5F), 8'h00);
      check(file_addr, 12'h25F, "indexed offset");
      // the word fetched behind the skip arrives in the nop cycle and must be dropped
      drive(xl(8'hFF), 8'h00);
      check(amode_q, ADDR_INDEXED, "indexed mode");
      check({discard_q, busy_q}, 2'h3, "single skip");
      step();
      check({acc_q, discard_q, busy_q}, {8'h1A, 2'h0}, "skipped word dropped");
      next_is_two_word = 1'b1;
      drive(ts(1'b0, 8'h60), 8'h00);
      check(file_addr, 12'hF60, "above offset window");
      step();
      check({discard_q, busy_q}, 2'h3, "first skip cycle");
      @(negedge ref_clk);
      check({discard_q, busy_q}, 2'h3, "second skip cycle");
      @(negedge ref_clk);
      check({discard_q, status_q}, 3'h1, "skip over, flags kept");
      $display("test skip done");
      stop_test();
   end

   initial
   begin
      repeat (400) @(posedge ref_clk);
      fail_count++;
      $display("watchdog expired");
      stop_test();
   end
endmodule : tb_tso_exec
